//--- include/adc_ctrl_defines.svh
// timing, width and code constants for the converter control block
// assumes a 10 MHz system clock; included by bare name
`ifndef ADC_CTRL_DEFINES_SVH
`define ADC_CTRL_DEFINES_SVH

`define ADC_BITS           10
`define ADC_MSB_IDX        4'h9
`define ADC_IDX_W          4
`define ADC_MSB_CODE       10'h200
`define ADC_ZERO_CODE      10'h000
`define CLK_PERIOD_NS      100
`define BIT_TRIAL_NS       2000
`define BIT_TRIAL_CYCLES   ((`BIT_TRIAL_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define CONV_CYCLES        (`ADC_BITS * `BIT_TRIAL_CYCLES)
`define DATA_VALID_NS      500
`define DATA_VALID_CYCLES  (`DATA_VALID_NS / `CLK_PERIOD_NS)
`define RELEASE_NS         1500
`define RELEASE_CYCLES     (`RELEASE_NS / `CLK_PERIOD_NS)
`define CLEAR_PULSE_NS     2000
`define CLEAR_PULSE_CYCLES ((`CLEAR_PULSE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define TIMER_W            5
`define AGE_W              8
`define SYNC_W             3
`define SYNC_BC            0
`define SYNC_OFS           1
`define SYNC_CMP           2
`define SYNC_RESET         3'h5

`endif

//--- include/adc_ctrl_pkg.sv
// types shared by the converter control block
// no dependencies
package adc_ctrl_pkg;

  typedef enum logic [2:0]
  {
    ST_STANDBY,
    ST_CONVERT,
    ST_HALTED,
    ST_SHOW,
    ST_RELEASE
  } ctrl_state_type;

endpackage : adc_ctrl_pkg

//--- logic/approximation_register.sv
// bit-trial sequencer: walks the code msb to lsb on the system clock
// assumes comp_below is already synchronised to clk_sys
`timescale 1ns/1ps
`include "adc_ctrl_defines.svh"

module approximation_register
  import adc_ctrl_pkg::*;
(
  input  wire logic                   clk_sys,
  input  wire logic                   rstn,
  input  wire logic                   start,
  input  wire logic                   clear,
  input  wire logic                   comp_below,
  output logic      [`ADC_BITS-1:0]   trial_code,
  output logic                        busy,
  output logic                        finish
);

  logic [`ADC_BITS-1:0]  code_reg,  code_next;
  logic [`ADC_IDX_W-1:0] idx_reg,   idx_next;
  logic [`TIMER_W-1:0]   tick_reg,  tick_next;
  logic                  busy_reg,  busy_next;
  logic                  fin_reg,   fin_next;
  logic [`AGE_W-1:0]     age_reg;

  wire trial_end = busy_reg && (tick_reg == `TIMER_W'(`BIT_TRIAL_CYCLES - 1));
  wire last_bit  = (idx_reg == `ADC_IDX_W'(0));

  // settle decision for the bit under trial, then arm the next one
  function automatic logic [`ADC_BITS-1:0] decide
  (
    input logic [`ADC_BITS-1:0]  code,
    input logic [`ADC_IDX_W-1:0] idx,
    input logic                  keep,
    input logic                  next_on
  );
    logic [`ADC_BITS-1:0] c;
    c      = code;
    c[idx] = keep;
    if (next_on && idx != `ADC_IDX_W'(0))
    begin
      c[idx - `ADC_IDX_W'(1)] = 1'b1;
    end
    return c;
  endfunction : decide

  always_comb
  begin
    code_next = code_reg;
    idx_next  = idx_reg;
    tick_next = tick_reg;
    busy_next = busy_reg;
    fin_next  = 1'b0;
    if (clear)
    begin
      busy_next = 1'b0;
      code_next = `ADC_ZERO_CODE;
    end
    else if (start)
    begin
      code_next = `ADC_MSB_CODE;
      idx_next  = `ADC_MSB_IDX;
      tick_next = '0;
      busy_next = 1'b1;
    end
    else if (trial_end)
    begin
      code_next = decide(code_reg, idx_reg, comp_below, !last_bit);
      tick_next = '0;
      if (last_bit)
      begin
        busy_next = 1'b0;
        fin_next  = 1'b1;
      end
      else
      begin
        idx_next = idx_reg - `ADC_IDX_W'(1);
      end
    end
    else if (busy_reg)
    begin
      tick_next = tick_reg + `TIMER_W'(1);
    end
  end

  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
    begin
      code_reg <= '0;
      idx_reg  <= '0;
      tick_reg <= '0;
      busy_reg <= 1'b0;
      fin_reg  <= 1'b0;
    end
    else
    begin
      code_reg <= code_next;
      idx_reg  <= idx_next;
      tick_reg <= tick_next;
      busy_reg <= busy_next;
      fin_reg  <= fin_next;
    end
  end

  // helper: cycles since start, for the bounded-time check
  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
      age_reg <= '0;
    else if (start || !busy_reg)
      age_reg <= '0;
    else
      age_reg <= age_reg + `AGE_W'(1);
  end

  assign trial_code = code_reg;
  assign busy       = busy_reg;
  assign finish     = fin_reg;

  localparam int CONV_MAX = `CONV_CYCLES;

  AST_MSB_FIRST: assert property (@(posedge clk_sys) disable iff (!rstn)
    (start && !clear) |=> (code_reg == `ADC_MSB_CODE) && (idx_reg == `ADC_MSB_IDX))
    else $error("conversion did not begin with the msb trial");

  AST_BIT_DECIDE: assert property (@(posedge clk_sys) disable iff (!rstn)
    (trial_end && !clear && !start) |=> code_reg[$past(idx_reg)] == $past(comp_below))
    else $error("trial bit not set by comparator decision");

  AST_BOUNDED_TIME: assert property (@(posedge clk_sys) disable iff (!rstn)
    busy_reg |-> (int'(age_reg) < CONV_MAX))
    else $error("conversion ran past its fixed length");

endmodule : approximation_register

//--- logic/adc_blank_convert_control.sv
// blank/convert control and three-state result outputs of a 10-bit converter
// assumes all pin inputs are asynchronous; the analog comparator output is one
// of them and the trial code drives an external current dac
`timescale 1ns/1ps
`include "adc_ctrl_defines.svh"

module adc_blank_convert_control
  import adc_ctrl_pkg::*;
(
  input  wire logic                  clk_sys,
  input  wire logic                  rstn,
  input  wire logic                  blank_convert_n,
  input  wire logic                  offset_open,
  input  wire logic                  comp_below,
  output logic      [`ADC_BITS-1:0]  dac_code,
  output logic                       bipolar_offset_en,
  output logic      [`ADC_BITS-1:0]  result_out,
  output logic                       result_oe,
  output logic                       conversion_done_n
);

  // two-stage synchronisers for every pin input
  logic [`SYNC_W-1:0] sync1_reg;
  logic [`SYNC_W-1:0] sync2_reg;
  wire  [`SYNC_W-1:0] pins_in = {comp_below, offset_open, blank_convert_n};

  // offset select resets to unipolar so range control does not blip after reset
  localparam logic [`SYNC_W-1:0] SYNC_RST = `SYNC_RESET;

  genvar g;
  generate
    for (g = 0; g < `SYNC_W; g++)
    begin : gen_sync
      always_ff @(posedge clk_sys or negedge rstn)
      begin
        if (!rstn)
        begin
          sync1_reg[g] <= SYNC_RST[g];
          sync2_reg[g] <= SYNC_RST[g];
        end
        else
        begin
          sync1_reg[g] <= pins_in[g];
          sync2_reg[g] <= sync1_reg[g];
        end
      end
    end
  endgenerate

  wire bc_high  = sync2_reg[`SYNC_BC];
  wire ofs_open = sync2_reg[`SYNC_OFS];
  wire cmp_lo   = sync2_reg[`SYNC_CMP];

  ctrl_state_type       state_reg,  state_next;
  logic [`TIMER_W-1:0]  timer_reg,  timer_next;
  logic [`ADC_BITS-1:0] result_reg, result_next;
  logic                 oe_reg,     oe_next;
  logic                 done_n_reg, done_n_next;
  logic                 bip_reg;
  logic                 seq_start;
  logic                 seq_clear;

  wire [`ADC_BITS-1:0] trial_code;
  wire                 seq_busy;
  wire                 seq_finish;

  approximation_register u_trials
  (
    .clk_sys    (clk_sys),
    .rstn       (rstn),
    .start      (seq_start),
    .clear      (seq_clear),
    .comp_below (cmp_lo),
    .trial_code (trial_code),
    .busy       (seq_busy),
    .finish     (seq_finish)
  );

  wire release_end = (timer_reg == `TIMER_W'(`RELEASE_CYCLES - 1));
  wire clear_reach = (timer_reg == `TIMER_W'(`CLEAR_PULSE_CYCLES - 1));

  // clear only while the line stays high, else a restart from halt is swallowed
  assign seq_clear = (state_reg == ST_HALTED) && bc_high;

  always_comb
  begin
    state_next  = state_reg;
    timer_next  = timer_reg;
    result_next = result_reg;
    oe_next     = oe_reg;
    done_n_next = done_n_reg;
    seq_start   = 1'b0;
    case (state_reg)
      ST_STANDBY:
      begin
        oe_next     = 1'b0;
        done_n_next = 1'b1;
        if (!bc_high)
        begin
          seq_start  = 1'b1;
          state_next = ST_CONVERT;
        end
      end
      ST_CONVERT:
      begin
        // outputs keep whatever they showed when the conversion began
        if (bc_high)
        begin
          timer_next = '0;
          state_next = ST_HALTED;
        end
        else if (seq_finish)
        begin
          result_next = trial_code;
          oe_next     = 1'b1;
          done_n_next = 1'b0;
          state_next  = ST_SHOW;
        end
      end
      ST_HALTED:
      begin
        // a short blip restarts at once; a long one parks the converter cleared
        if (!bc_high)
        begin
          seq_start  = 1'b1;
          state_next = ST_CONVERT;
        end
        else if (clear_reach)
        begin
          state_next = ST_STANDBY;
        end
        else
        begin
          timer_next = timer_reg + `TIMER_W'(1);
        end
      end
      ST_SHOW:
      begin
        if (bc_high)
        begin
          timer_next = '0;
          state_next = ST_RELEASE;
        end
      end
      ST_RELEASE:
      begin
        // low levels here are not honoured until blanking completes
        if (release_end)
        begin
          oe_next     = 1'b0;
          done_n_next = 1'b1;
          state_next  = ST_STANDBY;
        end
        else
        begin
          timer_next = timer_reg + `TIMER_W'(1);
        end
      end
      default:
      begin
        state_next = ST_STANDBY;
      end
    endcase
  end

  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
    begin
      state_reg  <= ST_STANDBY;
      timer_reg  <= '0;
      result_reg <= '0;
      oe_reg     <= 1'b0;
      done_n_reg <= 1'b1;
    end
    else
    begin
      state_reg  <= state_next;
      timer_reg  <= timer_next;
      result_reg <= result_next;
      oe_reg     <= oe_next;
      done_n_reg <= done_n_next;
    end
  end

  // range select is static; the offset current shifts the code by half scale
  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
      bip_reg <= 1'b0;
    else
      bip_reg <= ofs_open;
  end

  assign dac_code          = trial_code;
  assign bipolar_offset_en = bip_reg;
  assign result_out        = result_reg;
  assign result_oe         = oe_reg;
  assign conversion_done_n = done_n_reg;

  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rstn);

  localparam int DV_MAX  = `DATA_VALID_CYCLES;
  localparam int REL_CYC = `RELEASE_CYCLES;
  localparam int CLR_CYC = `CLEAR_PULSE_CYCLES;

  sequence s_show_then_high;
    (state_reg == ST_SHOW) && bc_high;
  endsequence

  sequence s_halt_entry;
    (state_reg == ST_CONVERT) && bc_high;
  endsequence

  AST_STANDBY_BLANK: assert property (
    ((state_reg == ST_STANDBY) && $past(state_reg == ST_STANDBY)) |-> (!oe_reg && done_n_reg))
    else $error("standby left outputs enabled or done low");

  AST_START_HOLD: assert property (
    seq_start |=> $stable(done_n_reg) && $stable(oe_reg) && $stable(result_reg))
    else $error("outputs moved when a conversion started");

  AST_DATA_VALID: assert property (
    $fell(done_n_reg) |-> ##[0:DV_MAX] (oe_reg && result_reg == $past(trial_code)))
    else $error("result not enabled in time after done fell");

  AST_RELEASE_TIME: assert property (
    s_show_then_high |=> (!done_n_reg && oe_reg) [*8] ##[0:REL_CYC] (done_n_reg && !oe_reg))
    else $error("release of done and outputs not at the set delay");

  AST_ABORT_HOLD: assert property (
    s_halt_entry |=> (state_reg == ST_HALTED) && $stable(done_n_reg) && $stable(oe_reg))
    else $error("abort changed done or result lines");

  AST_CLEAR_PULSE: assert property (
    s_halt_entry ##1 bc_high [*8] |-> ##[0:CLR_CYC] (state_reg != ST_HALTED))
    else $error("long high pulse did not clear the converter");

  AST_HOLD_RESULT: assert property (
    ((state_reg == ST_SHOW) && !bc_high) |=>
      ((state_reg == ST_SHOW) && !done_n_reg && oe_reg && $stable(result_reg)))
    else $error("result not held while input stays low");

  AST_RANGE_SELECT: assert property (
    $changed(ofs_open) |-> ##1 (bip_reg == $past(ofs_open)))
    else $error("offset select not followed by range control");

endmodule : adc_blank_convert_control

//--- sim/analog_front_model.sv
// comparator front end of the converter: weighted dac sum against an analog level
// the testbench sets the level in half-lsb steps; the model itself has no clock
`timescale 1ns/1ps

module analog_front_model
(
  input  wire logic        [9:0]  dac_code,
  input  wire logic               bipolar_offset_en,
  input  wire logic signed [11:0] vin_half_lsb,
  output logic                    comp_below
);
  logic signed [12:0] level;

  // a half-lsb bias centres each code on its step
  // the offset current shifts the range by half scale
  assign level = vin_half_lsb + (bipolar_offset_en ? 13'sh0400 : 13'sh0000) + 13'sh0001;
  assign comp_below = $signed({2'b00, dac_code, 1'b0}) < level;

endmodule : analog_front_model

//--- sim/testbench.sv
// self-checking bench for the blank/convert control block
// assumes the analog front model answers the trial code at once
`timescale 1ns/1ps
`include "adc_ctrl_defines.svh"

module testbench;
  import adc_ctrl_pkg::*;

  logic                    clk_sys;
  logic                    rstn;
  logic                    blank_convert_n;
  logic                    offset_open;
  logic                    comp_below;
  logic             [9:0]  dac_code;
  logic                    bipolar_offset_en;
  logic             [9:0]  result_out;
  logic                    result_oe;
  logic                    conversion_done_n;
  logic signed      [11:0] vin_half_lsb;
  int                      errors;
  int                      samples_checked;

  adc_blank_convert_control uut
  (
    .clk_sys           (clk_sys),
    .rstn              (rstn),
    .blank_convert_n   (blank_convert_n),
    .offset_open       (offset_open),
    .comp_below        (comp_below),
    .dac_code          (dac_code),
    .bipolar_offset_en (bipolar_offset_en),
    .result_out        (result_out),
    .result_oe         (result_oe),
    .conversion_done_n (conversion_done_n)
  );

  analog_front_model front
  (
    .dac_code          (dac_code),
    .bipolar_offset_en (bipolar_offset_en),
    .vin_half_lsb      (vin_half_lsb),
    .comp_below        (comp_below)
  );

  initial clk_sys = 1'b0;
  always #50 clk_sys = ~clk_sys;

  task automatic end_sim();
    if (errors == 0 && samples_checked > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : end_sim

  task automatic check1(input string name, input logic exp, input logic seen);
    samples_checked++;
    if (seen !== exp)
    begin
      errors++;
      $display("wrong value %s expected %b seen %b", name, exp, seen);
    end
  endtask : check1

  task automatic check10(input string name, input logic [9:0] exp, input logic [9:0] seen);
    samples_checked++;
    if (seen !== exp)
    begin
      errors++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask : check10

  task automatic check_blank();
    check1("result_oe", 1'b0, result_oe);
    check1("conversion_done_n", 1'b1, conversion_done_n);
  endtask : check_blank

  // one full multiplexed cycle: select, wait for done, read, hold, blank
  task automatic convert(input logic signed [11:0] v, input logic [9:0] exp);
    int n;
    @(posedge clk_sys);
    vin_half_lsb    <= v;
    blank_convert_n <= 1'b0;
    repeat (10) @(posedge clk_sys);
    @(negedge clk_sys);
    check10("dac_code", 10'h0200, dac_code);
    check_blank();
    n = 10;
    while (conversion_done_n !== 1'b0 && n < 400)
    begin
      @(negedge clk_sys);
      n++;
    end
    check1("conversion_time", 1'b1, n >= 200 && n <= 215);
    check1("result_oe", 1'b1, result_oe);
    check10("result_out", exp, result_out);
    repeat (100) @(negedge clk_sys);
    check1("result_oe", 1'b1, result_oe);
    check1("conversion_done_n", 1'b0, conversion_done_n);
    check10("result_out", exp, result_out);
    @(posedge clk_sys);
    blank_convert_n <= 1'b1;
    repeat (15) @(negedge clk_sys);
    check1("conversion_done_n", 1'b0, conversion_done_n);
    repeat (4) @(negedge clk_sys);
    check_blank();
    // host keeps the line high past the minimum blank width
    repeat (10) @(posedge clk_sys);
  endtask : convert

  // conversion broken off by a high pulse of high_cycles, then a fresh one
  task automatic abort_then_convert(input int high_cycles, input logic signed [11:0] v,
                                    input logic [9:0] exp);
    vin_half_lsb    <= v;
    blank_convert_n <= 1'b0;
    repeat (60) @(posedge clk_sys);
    blank_convert_n <= 1'b1;
    repeat (high_cycles) @(posedge clk_sys);
    @(negedge clk_sys);
    check_blank();
    check10("dac_code", `ADC_ZERO_CODE, dac_code);
    convert(v, exp);
  endtask : abort_then_convert

  // pulse mode: line rests low, a high pulse blanks the old result and restarts
  task automatic pulse_convert(input logic signed [11:0] v, input logic [9:0] exp);
    int n;
    @(posedge clk_sys);
    vin_half_lsb    <= v;
    blank_convert_n <= 1'b1;
    repeat (20) @(posedge clk_sys);
    blank_convert_n <= 1'b0;
    n = 0;
    while (conversion_done_n !== 1'b0 && n < 400)
    begin
      @(negedge clk_sys);
      n++;
    end
    check1("conversion_time", 1'b1, n >= 200 && n <= 215);
    check1("result_oe", 1'b1, result_oe);
    check10("result_out", exp, result_out);
    repeat (50) @(negedge clk_sys);
    check1("conversion_done_n", 1'b0, conversion_done_n);
    check10("result_out", exp, result_out);
  endtask : pulse_convert

  initial
  begin
    repeat (20000) @(posedge clk_sys);
    errors++;
    end_sim();
  end

  initial
  begin
    rstn            = 1'b0;
    blank_convert_n = 1'b1;
    offset_open     = 1'b0;
    vin_half_lsb    = 12'sh000;
    errors          = 0;
    samples_checked = 0;
    repeat (8) @(posedge clk_sys);
    rstn <= 1'b1;
    repeat (30) @(negedge clk_sys);
    check_blank();
    check1("bipolar_offset_en", 1'b0, bipolar_offset_en);
    // unipolar: straight binary, level 2n gives code n
    convert(12'sh000, 10'h0000);
    convert(12'sh554, 10'h02aa);
    convert(12'sh7fe, 10'h03ff);
    @(posedge clk_sys);
    offset_open <= 1'b1;
    repeat (6) @(negedge clk_sys);
    check1("bipolar_offset_en", 1'b1, bipolar_offset_en);
    // bipolar: negative full scale, zero, one step below positive full scale
    convert(-12'sh400, 10'h0000);
    convert(12'sh000, 10'h0200);
    convert(12'sh3fe, 10'h03ff);
    abort_then_convert(5, 12'sh0c8, 10'h0264);
    abort_then_convert(30, -12'sh0c8, 10'h019c);
    pulse_convert(12'sh000, 10'h0200);
    pulse_convert(-12'sh0c8, 10'h019c);
    end_sim();
  end

endmodule : testbench
